// ===== odsf_diag_status.sv
// Diagnostic status, control and flag page of an optical transceiver, APB slave
//
// Function
// - Checksum byte 95 stored, returned on reads
// - Byte 127 writes accepted, no effect
// - Bytes 128-247 are writable user storage
// - Control bit 7 reads transmitter-off pin
// - Control bit 6 is software transmitter-off
// - Transmitter off when pin OR software bit
// - Control bit 4 reads bandwidth-select pin
// - Bandwidth pin ignored, always full bandwidth
// - Control bit 2 mirrors laser-fault output
// - Control bit 1 mirrors signal-lost output
// - Control bit 0 low once measurements valid
// - Byte 112 alarm flags, four quantities
// - Byte 113 receive-power high/low alarm flags
// - Byte 116 warning flags, same layout
// - Byte 117 bit 7 receive-power high warning
// - Live values big-endian in bytes 96-105
// - Temperature signed, compared as signed
// - Checksum covers bytes 0 through 94
`timescale 1ns/10ps

module odsf_diag_status #(
   parameter int unsigned MEAS_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [odsf_pkg::ODSF_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_disable_pin,
   input wire logic rate_select_pin,
   input wire logic laser_fault_in,
   input wire logic rx_signal_absent,
   input wire logic [MEAS_W-1:0] meas_temp,
   input wire logic [MEAS_W-1:0] meas_supply,
   input wire logic [MEAS_W-1:0] meas_bias,
   input wire logic [MEAS_W-1:0] meas_tx_power,
   input wire logic [MEAS_W-1:0] meas_rx_power,
   input wire logic meas_valid,
   output logic tx_off,
   output logic tx_fault,
   output logic signal_lost_indication,
   output logic full_bandwidth
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (MEAS_W != 16) begin : g_bad_width
      $error("odsf_diag_status: measurements must be 16 bits wide");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] mem_r [0:odsf_pkg::ODSF_PAGE_BYTES-1]; // Page storage
   logic [1:0] txdis_sync_r; // Transmitter-off pin synchroniser
   logic [1:0] rate_sync_r; // Bandwidth-select pin synchroniser
   logic [1:0] fault_sync_r; // Laser fault synchroniser
   logic [1:0] los_sync_r; // Signal absent synchroniser
   logic soft_txoff_r; // Software transmitter-off bit
   logic not_ready_r; // Measurements not yet valid
   logic factory_unlock_r; // Opens bytes 0-95 for writing
   logic [7:0] alarm_main_r; // Alarm flags, four quantities
   logic [7:0] alarm_rx_r; // Receive power alarm flags
   logic [7:0] warn_main_r; // Warning flags, four quantities
   logic [7:0] warn_rx_r; // Receive power warning flags
   logic tx_off_r; // Transmitter disable output
   logic tx_fault_r; // Fault output
   logic los_r; // Signal lost output
   logic full_bw_r; // Bandwidth output
   odsf_pkg::odsf_apb_t apb_state_r; // Bus answer state
   odsf_pkg::odsf_apb_t apb_state_nxt; // Next bus state
   logic [31:0] prdata_r; // Registered read data
   logic pslverr_r; // Registered error answer
   logic [9:0] idx; // Register index from address
   logic acc; // Access phase present
   logic commit; // Edge where transfer completes
   logic wr_commit; // Write takes effect
   logic mapped; // Index is decoded
   logic [7:0] rd_byte; // Read data before register
   logic [7:0] ctrl_stat; // Assembled control/status byte
   logic [MEAS_W-1:0] meas_in [0:odsf_pkg::N_QTY-1]; // Live inputs
   logic [odsf_pkg::N_QTY-1:0] hi_alarm; // High alarm compares
   logic [odsf_pkg::N_QTY-1:0] lo_alarm; // Low alarm compares
   logic [odsf_pkg::N_QTY-1:0] hi_warn; // High warning compares
   logic [odsf_pkg::N_QTY-1:0] lo_warn; // Low warning compares

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign idx = paddr[odsf_pkg::ODSF_ADDR_W-1:2];
   assign acc = psel && penable;
   assign commit = acc && (apb_state_r == odsf_pkg::ODSF_APB_DONE);
   assign wr_commit = commit && pwrite && !pslverr_r;
   assign mapped = (idx < 10'(odsf_pkg::ODSF_PAGE_BYTES)) || (idx == odsf_pkg::IDX_FACTORY_CTL);

   // ----------------------------------------------------------------
   // Measurement inputs as an array, one slot per quantity
   // ----------------------------------------------------------------
   assign meas_in[0] = meas_temp;
   assign meas_in[1] = meas_supply;
   assign meas_in[2] = meas_bias;
   assign meas_in[3] = meas_tx_power;
   assign meas_in[4] = meas_rx_power;

   // ----------------------------------------------------------------
   // Threshold compares against the stored big-endian pairs
   // ----------------------------------------------------------------
   for (genvar q = 0; q < odsf_pkg::N_QTY; q++) begin : g_cmp
      localparam int unsigned BASE = q * odsf_pkg::THR_BYTES_PER_QTY;
      logic [15:0] thr_ha; // High alarm threshold
      logic [15:0] thr_la; // Low alarm threshold
      logic [15:0] thr_hw; // High warning threshold
      logic [15:0] thr_lw; // Low warning threshold
      // Pairs: most significant byte first
      assign thr_ha = {mem_r[BASE + 2 * odsf_pkg::THR_HI_ALARM], mem_r[BASE + 2 * odsf_pkg::THR_HI_ALARM + 1]};
      assign thr_la = {mem_r[BASE + 2 * odsf_pkg::THR_LO_ALARM], mem_r[BASE + 2 * odsf_pkg::THR_LO_ALARM + 1]};
      assign thr_hw = {mem_r[BASE + 2 * odsf_pkg::THR_HI_WARN], mem_r[BASE + 2 * odsf_pkg::THR_HI_WARN + 1]};
      assign thr_lw = {mem_r[BASE + 2 * odsf_pkg::THR_LO_WARN], mem_r[BASE + 2 * odsf_pkg::THR_LO_WARN + 1]};
      if (q == 0) begin : g_signed
         // Temperature is two's complement, compared signed
         assign hi_alarm[q] = $signed(meas_in[q]) > $signed(thr_ha);
         assign lo_alarm[q] = $signed(meas_in[q]) < $signed(thr_la);
         assign hi_warn[q] = $signed(meas_in[q]) > $signed(thr_hw);
         assign lo_warn[q] = $signed(meas_in[q]) < $signed(thr_lw);
      end else begin : g_unsigned
         // Other quantities are plain unsigned counts
         assign hi_alarm[q] = meas_in[q] > thr_ha;
         assign lo_alarm[q] = meas_in[q] < thr_la;
         assign hi_warn[q] = meas_in[q] > thr_hw;
         assign lo_warn[q] = meas_in[q] < thr_lw;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two stages each; only the second stage is read downstream
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txdis_sync_r <= 2'h0;
         rate_sync_r <= 2'h0;
         fault_sync_r <= 2'h0;
         los_sync_r <= 2'h0;
      end else begin
         txdis_sync_r <= {txdis_sync_r[0], tx_disable_pin};
         rate_sync_r <= {rate_sync_r[0], rate_select_pin};
         fault_sync_r <= {fault_sync_r[0], laser_fault_in};
         los_sync_r <= {los_sync_r[0], rx_signal_absent};
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   // Transmitter off, fault, signal lost and bandwidth outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_off_r <= 1'b1;
         tx_fault_r <= 1'b0;
         los_r <= 1'b0;
         full_bw_r <= 1'b1;
      end else begin
         tx_off_r <= txdis_sync_r[1] | soft_txoff_r;
         tx_fault_r <= fault_sync_r[1];
         los_r <= los_sync_r[1];
         full_bw_r <= 1'b1; // Pin level has no effect
      end
   end

   // ----------------------------------------------------------------
   // Control bits written by software
   // ----------------------------------------------------------------
   // Software transmitter-off and factory unlock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_txoff_r <= odsf_pkg::SOFT_TXOFF_RST;
         factory_unlock_r <= odsf_pkg::UNLOCK_RST;
      end else if (wr_commit) begin
         if (idx == odsf_pkg::IDX_CTRL_STAT) begin
            soft_txoff_r <= pwdata[odsf_pkg::CS_SOFT_TXOFF_BIT];
         end
         if (idx == odsf_pkg::IDX_FACTORY_CTL) begin
            factory_unlock_r <= pwdata[odsf_pkg::FACTORY_UNLOCK_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Measurement readiness
   // ----------------------------------------------------------------
   // Stays set until the first valid measurement arrives
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         not_ready_r <= odsf_pkg::NOT_READY_RST;
      end else if (meas_valid) begin
         not_ready_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Alarm and warning flags
   // ----------------------------------------------------------------
   // Recomputed from each new measurement, never latched
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_main_r <= odsf_pkg::FLAGS_RST;
         alarm_rx_r <= odsf_pkg::FLAGS_RST;
         warn_main_r <= odsf_pkg::FLAGS_RST;
         warn_rx_r <= odsf_pkg::FLAGS_RST;
      end else if (meas_valid) begin
         for (int q = 0; q < 4; q++) begin
            alarm_main_r[7 - 2 * q] <= hi_alarm[q];
            alarm_main_r[6 - 2 * q] <= lo_alarm[q];
            warn_main_r[7 - 2 * q] <= hi_warn[q];
            warn_main_r[6 - 2 * q] <= lo_warn[q];
         end
         alarm_rx_r <= FLAGS_RX(hi_alarm[odsf_pkg::QTY_RX], lo_alarm[odsf_pkg::QTY_RX]);
         warn_rx_r <= FLAGS_RX(hi_warn[odsf_pkg::QTY_RX], lo_warn[odsf_pkg::QTY_RX]);
      end
   end

   // Receive power flag byte: high in bit 7, low in bit 6, rest zero
   function automatic logic [7:0] FLAGS_RX(input logic hi, input logic lo);
      logic [7:0] v;
      v = 8'h00;
      v[odsf_pkg::FLAG_RX_HIGH_BIT] = hi;
      v[odsf_pkg::FLAG_RX_LOW_BIT] = lo;
      return v;
   endfunction : FLAGS_RX

   // ----------------------------------------------------------------
   // Page storage
   // ----------------------------------------------------------------
   // Factory bytes, user bytes and live measurement bytes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < odsf_pkg::ODSF_PAGE_BYTES; i++) begin
            mem_r[i] <= odsf_pkg::MEM_RST;
         end
      end else begin
         if (wr_commit) begin
            if (idx <= odsf_pkg::IDX_CHECKSUM && factory_unlock_r) begin
               // Thresholds, calibration and checksum: factory only
               mem_r[idx[7:0]] <= pwdata[7:0];
            end else if (idx >= odsf_pkg::IDX_USER_FIRST && idx <= odsf_pkg::IDX_USER_LAST) begin
               mem_r[idx[7:0]] <= pwdata[7:0];
            end
            // Writes to the legacy byte are taken and dropped
         end
         if (meas_valid) begin
            for (int q = 0; q < odsf_pkg::N_QTY; q++) begin
               // Live values, most significant byte first
               mem_r[32'(odsf_pkg::IDX_LIVE_FIRST) + 2 * q] <= meas_in[q][15:8];
               mem_r[32'(odsf_pkg::IDX_LIVE_FIRST) + 2 * q + 1] <= meas_in[q][7:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   // Control/status byte from live pin levels and control bits
   always_comb begin
      ctrl_stat = 8'h00;
      ctrl_stat[odsf_pkg::CS_TXOFF_PIN_BIT] = txdis_sync_r[1];
      ctrl_stat[odsf_pkg::CS_SOFT_TXOFF_BIT] = soft_txoff_r;
      ctrl_stat[odsf_pkg::CS_RATE_BIT] = rate_sync_r[1];
      ctrl_stat[odsf_pkg::CS_FAULT_BIT] = tx_fault_r;
      ctrl_stat[odsf_pkg::CS_LOS_BIT] = los_r;
      ctrl_stat[odsf_pkg::CS_NOT_READY_BIT] = not_ready_r;
   end

   // Byte selection by index; reserved bytes read zero
   always_comb begin
      rd_byte = 8'h00;
      if (idx <= odsf_pkg::IDX_CHECKSUM) begin
         rd_byte = mem_r[idx[7:0]];
      end else if (idx >= odsf_pkg::IDX_LIVE_FIRST && idx <= odsf_pkg::IDX_LIVE_LAST) begin
         rd_byte = mem_r[idx[7:0]];
      end else if (idx >= odsf_pkg::IDX_USER_FIRST && idx <= odsf_pkg::IDX_USER_LAST) begin
         rd_byte = mem_r[idx[7:0]];
      end else begin
         case (idx)
            odsf_pkg::IDX_CTRL_STAT: begin
               rd_byte = ctrl_stat;
            end
            odsf_pkg::IDX_ALARM_MAIN: begin
               rd_byte = alarm_main_r;
            end
            odsf_pkg::IDX_ALARM_RX: begin
               rd_byte = alarm_rx_r;
            end
            odsf_pkg::IDX_WARN_MAIN: begin
               rd_byte = warn_main_r;
            end
            odsf_pkg::IDX_WARN_RX: begin
               rd_byte = warn_rx_r;
            end
            odsf_pkg::IDX_FACTORY_CTL: begin
               rd_byte = {7'h00, factory_unlock_r};
            end
            default: begin
               rd_byte = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // One wait state: ready rises in the second access cycle
   always_comb begin
      apb_state_nxt = apb_state_r;
      case (apb_state_r)
         odsf_pkg::ODSF_APB_WAIT: begin
            if (acc) begin
               apb_state_nxt = odsf_pkg::ODSF_APB_DONE;
            end
         end
         odsf_pkg::ODSF_APB_DONE: begin
            apb_state_nxt = odsf_pkg::ODSF_APB_WAIT;
         end
         default: begin
            apb_state_nxt = odsf_pkg::ODSF_APB_WAIT;
         end
      endcase
   end

   // State, ready, read data and error, all registered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         apb_state_r <= odsf_pkg::ODSF_APB_WAIT;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         apb_state_r <= apb_state_nxt;
         if (acc && apb_state_r == odsf_pkg::ODSF_APB_WAIT) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_r <= !mapped;
         end else if (commit) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = (apb_state_r == odsf_pkg::ODSF_APB_DONE);
   assign pslverr = pslverr_r;
   assign tx_off = tx_off_r;
   assign tx_fault = tx_fault_r;
   assign signal_lost_indication = los_r;
   assign full_bandwidth = full_bw_r;

endmodule : odsf_diag_status

// ===== odsf_pkg.sv
// Constants, field layout and state type of the optical diagnostic status page
package odsf_pkg;

   // ----------------------------------------------------------------
   // Page geometry and register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int unsigned ODSF_PAGE_BYTES = 256;
   localparam int unsigned ODSF_ADDR_W = 12;
   localparam logic [9:0] IDX_FACTORY_LAST = 10'h05E;
   localparam logic [9:0] IDX_CHECKSUM = 10'h05F;
   localparam logic [9:0] IDX_LIVE_FIRST = 10'h060;
   localparam logic [9:0] IDX_LIVE_LAST = 10'h069;
   localparam logic [9:0] IDX_CTRL_STAT = 10'h06E;
   localparam logic [9:0] IDX_ALARM_MAIN = 10'h070;
   localparam logic [9:0] IDX_ALARM_RX = 10'h071;
   localparam logic [9:0] IDX_WARN_MAIN = 10'h074;
   localparam logic [9:0] IDX_WARN_RX = 10'h075;
   localparam logic [9:0] IDX_LEGACY = 10'h07F;
   localparam logic [9:0] IDX_USER_FIRST = 10'h080;
   localparam logic [9:0] IDX_USER_LAST = 10'h0F7;
   localparam logic [9:0] IDX_FACTORY_CTL = 10'h100;

   // ----------------------------------------------------------------
   // Control/status byte fields
   // ----------------------------------------------------------------
   localparam int unsigned CS_TXOFF_PIN_BIT = 7;
   localparam int unsigned CS_SOFT_TXOFF_BIT = 6;
   localparam int unsigned CS_RATE_BIT = 4;
   localparam int unsigned CS_FAULT_BIT = 2;
   localparam int unsigned CS_LOS_BIT = 1;
   localparam int unsigned CS_NOT_READY_BIT = 0;
   localparam int unsigned FACTORY_UNLOCK_BIT = 0;

   // ----------------------------------------------------------------
   // Flag byte fields and threshold layout
   // ----------------------------------------------------------------
   localparam int unsigned N_QTY = 5;
   localparam int unsigned QTY_RX = 4;
   localparam int unsigned THR_BYTES_PER_QTY = 8;
   localparam int unsigned FLAG_RX_HIGH_BIT = 7;
   localparam int unsigned FLAG_RX_LOW_BIT = 6;
   localparam int unsigned THR_HI_ALARM = 0;
   localparam int unsigned THR_LO_ALARM = 1;
   localparam int unsigned THR_HI_WARN = 2;
   localparam int unsigned THR_LO_WARN = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic SOFT_TXOFF_RST = 1'b0;
   localparam logic NOT_READY_RST = 1'b1;
   localparam logic UNLOCK_RST = 1'b0;
   localparam logic [7:0] MEM_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;

   // ----------------------------------------------------------------
   // Bus answer state
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      ODSF_APB_WAIT = 1'b0,
      ODSF_APB_DONE = 1'b1
   } odsf_apb_t;

endpackage : odsf_pkg

// ===== odsf_sva.sv
// Port-level assertions for the diagnostic status page, bound to its top
`timescale 1ns/10ps

module odsf_sva_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_disable_pin,
   input wire logic laser_fault_in,
   input wire logic rx_signal_absent,
   input wire logic meas_valid,
   input wire logic tx_off,
   input wire logic tx_fault,
   input wire logic signal_lost_indication,
   input wire logic full_bandwidth
);
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic rd_ok; // Completed good read
   logic [9:0] idx; // Word index of the transfer
   assign rd_ok = pready && !pwrite && !pslverr;
   assign idx = paddr[11:2];

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   a_bw_full: assert property (full_bandwidth)
      else $error("full bandwidth output dropped");
   a_txoff_pin: assert property (tx_disable_pin [*3] |=> tx_off)
      else $error("tx_off low while pin held");
   a_fault_set: assert property (laser_fault_in [*3] |=> tx_fault)
      else $error("tx_fault not following input");
   a_fault_clr: assert property (!laser_fault_in [*3] |=> !tx_fault)
      else $error("tx_fault stuck high");
   a_los_set: assert property (rx_signal_absent [*3] |=> signal_lost_indication)
      else $error("signal lost output not following input");
   a_rd_fault: assert property (rd_ok && idx == odsf_pkg::IDX_CTRL_STAT |-> prdata[2] == $past(tx_fault))
      else $error("control bit 2 differs from fault output");
   a_rd_lost: assert property (rd_ok && idx == odsf_pkg::IDX_CTRL_STAT
      |-> prdata[1] == $past(signal_lost_indication))
      else $error("control bit 1 differs from signal lost output");
   a_ctrl_rsvd: assert property (rd_ok && idx == odsf_pkg::IDX_CTRL_STAT |-> !prdata[5] && !prdata[3])
      else $error("control reserved bits set");
   a_alarm_rsvd: assert property (rd_ok && idx == odsf_pkg::IDX_ALARM_RX |-> prdata[5:0] == 6'h00)
      else $error("rx alarm reserved bits set");
   a_warn_rsvd: assert property (rd_ok && idx == odsf_pkg::IDX_WARN_RX |-> prdata[5:0] == 6'h00)
      else $error("rx warning reserved bits set");

   // ------------------------------------------------
   // Cover
   // ------------------------------------------------
   c_ctrl_rd: cover property (rd_ok && idx == odsf_pkg::IDX_CTRL_STAT);
   c_err: cover property (pready && pslverr);
   c_meas: cover property (meas_valid);
endmodule : odsf_sva_chk

bind odsf_diag_status odsf_sva_chk sva_u (.ref_clk, .rst_n, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .tx_disable_pin, .laser_fault_in, .rx_signal_absent, .meas_valid, .tx_off, .tx_fault,
   .signal_lost_indication, .full_bandwidth);

// ===== odsf_host_bfm.sv
// Host controller model: APB master issuing byte accesses
`timescale 1ns/10ps

module odsf_host_bfm (
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // ------------------------------------------------
   // One transfer; request held until pready seen
   // ------------------------------------------------
   task automatic xfer(input logic w, input logic [9:0] i, input logic [7:0] d,
      output logic [31:0] q, output logic e, output logic ok);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      ok = (pready === 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : odsf_host_bfm

// ===== optical_module_diag_status_flags_tb.sv
// Self-checking bench for the diagnostic status page
`timescale 1ns/10ps

module optical_module_diag_status_flags_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic tx_disable_pin = 1'b0;
   logic rate_select_pin = 1'b0;
   logic laser_fault_in = 1'b0;
   logic rx_signal_absent = 1'b0;
   logic [15:0] meas_temp = 16'h0000;
   logic [15:0] meas_supply = 16'h0000;
   logic [15:0] meas_bias = 16'h0000;
   logic [15:0] meas_tx_power = 16'h0000;
   logic [15:0] meas_rx_power = 16'h0000;
   logic meas_valid = 1'b0;
   logic tx_off, tx_fault, signal_lost_indication, full_bandwidth;
   int err_count = 0;
   int n_compared = 0;
   localparam logic [9:0] CS = odsf_pkg::IDX_CTRL_STAT;

   always #2 ref_clk = ~ref_clk;

   odsf_host_bfm host_u (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   odsf_diag_status #(.MEAS_W(16)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_disable_pin(tx_disable_pin),
      .rate_select_pin(rate_select_pin), .laser_fault_in(laser_fault_in),
      .rx_signal_absent(rx_signal_absent), .meas_temp(meas_temp), .meas_supply(meas_supply),
      .meas_bias(meas_bias), .meas_tx_power(meas_tx_power), .meas_rx_power(meas_rx_power),
      .meas_valid(meas_valid), .tx_off(tx_off), .tx_fault(tx_fault),
      .signal_lost_indication(signal_lost_indication), .full_bandwidth(full_bandwidth));

   // ------------------------------------------------
   // Report and bus helpers
   // ------------------------------------------------
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d,
      output logic [31:0] q, output logic e);
      logic ok;
      host_u.xfer(w, i, d, q, e, ok);
      if (!ok) begin
         err_count++;
         complete_run();
      end
   endtask : bus

   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      bus(1'b1, i, d, q, e);
      chk("wr pslverr", 32'h0, {31'h0, e});
   endtask : wr

   task automatic rd(input logic [9:0] i, input logic [31:0] x);
      logic [31:0] q;
      logic e;
      bus(1'b0, i, 8'h00, q, e);
      chk("prdata", x, q);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask : rd

   // Load all live values with one update strobe
   task automatic meas(input logic [15:0] t, s, b, p, r);
      @(posedge ref_clk);
      {meas_temp, meas_supply, meas_bias, meas_tx_power, meas_rx_power} <= {t, s, b, p, r};
      meas_valid <= 1'b1;
      @(posedge ref_clk);
      meas_valid <= 1'b0;
      @(posedge ref_clk);
   endtask : meas

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_ctrl();
      rd(CS, 32'h01);
      wr(CS, 8'hFF);
      repeat (4) @(posedge ref_clk);
      chk("tx_off soft", 32'h1, {31'h0, tx_off});
      rd(CS, 32'h41);
      wr(CS, 8'h00);
      {tx_disable_pin, rate_select_pin, laser_fault_in, rx_signal_absent} <= 4'hF;
      repeat (4) @(posedge ref_clk);
      rd(CS, 32'h97);
      chk("tx_off pin", 32'h1, {31'h0, tx_off});
      {tx_disable_pin, rate_select_pin, laser_fault_in, rx_signal_absent} <= 4'h0;
      repeat (4) @(posedge ref_clk);
      chk("tx_off clear", 32'h0, {31'h0, tx_off});
      chk("full_bandwidth", 32'h1, {31'h0, full_bandwidth});
   endtask : t_ctrl

   task automatic t_store();
      wr(10'h080, 8'hA5);
      wr(10'h0F7, 8'h3C);
      wr(10'h07F, 8'h77);
      rd(10'h080, 32'hA5);
      rd(10'h0F7, 32'h3C);
      rd(10'h07F, 32'h00);
      wr(10'h05F, 8'h5A);
      rd(10'h05F, 32'h00);
      wr(odsf_pkg::IDX_FACTORY_CTL, 8'h01);
      wr(10'h05F, 8'h5A);
      wr(odsf_pkg::IDX_FACTORY_CTL, 8'h00);
      wr(10'h05F, 8'h11);
      rd(10'h05F, 32'h5A);
   endtask : t_store

   task automatic t_flags();
      logic [15:0] th [8] = '{16'h0A00, 16'hF600, 16'h0500, 16'hFB00,
         16'h9000, 16'h1000, 16'h8000, 16'h2000};
      wr(odsf_pkg::IDX_FACTORY_CTL, 8'h01);
      for (int i = 0; i < 20; i++) begin
         wr(10'(2 * i), th[(i < 4) ? i : 4 + i % 4][15:8]);
         wr(10'(2 * i + 1), th[(i < 4) ? i : 4 + i % 4][7:0]);
      end
      wr(odsf_pkg::IDX_FACTORY_CTL, 8'h00);
      meas(16'hF000, 16'hA000, 16'h1800, 16'h0800, 16'h8800);
      rd(odsf_pkg::IDX_ALARM_MAIN, 32'h61);
      rd(odsf_pkg::IDX_ALARM_RX, 32'h00);
      rd(odsf_pkg::IDX_WARN_MAIN, 32'h65);
      rd(odsf_pkg::IDX_WARN_RX, 32'h80);
      meas(16'h0B00, 16'h5000, 16'h0F00, 16'h9100, 16'h0812);
      rd(odsf_pkg::IDX_ALARM_MAIN, 32'h86);
      rd(odsf_pkg::IDX_ALARM_RX, 32'h40);
      rd(odsf_pkg::IDX_WARN_MAIN, 32'h86);
      rd(odsf_pkg::IDX_WARN_RX, 32'h40);
      rd(10'h060, 32'h0B);
      rd(10'h069, 32'h12);
      rd(CS, 32'h00);
   endtask : t_flags

   task automatic t_unmapped();
      logic [31:0] q;
      logic e;
      bus(1'b0, 10'h101, 8'h00, q, e);
      chk("unmapped pslverr", 32'h1, {31'h0, e});
      chk("unmapped prdata", 32'h0, q);
   endtask : t_unmapped

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_ctrl();
      t_store();
      t_flags();
      t_unmapped();
      complete_run();
   end
endmodule : optical_module_diag_status_flags_tb
